// ==== dedv_pkg.sv ====
// Purpose: shared constants and types for the dual-edge output clock dividers
// Assumes: AXI4-Lite, register byte address is four times the register index
// Notes:   ten dividers, five pairs, two channels
// How it works
// - dividers count both input clock edges
// - dividers stay off until a sync request or the resync after an update strobe that changes a ratio
// - both dividers of a pair share one clock
// - source select zero routes loop, one sysclk
// - alternate source is system clock over three
// - resync mask keeps sysclk dividers running
// - each divider takes a 32-bit ratio
// - new ratio acts only after update strobe
// - half step adds one half to ratio
// - half step change waits for update strobe
// - each divider has its own soft reset
// - ratio change resyncs the unmasked pairs of its channel
// - feedback select picks divider for digital loop
// - first divider of pair shifts falling edges
package dedv_pkg;
   localparam int DEDV_NDIV  = 10;
   localparam int DEDV_NPAIR = 5;
   localparam int DEDV_NFB   = 12;
   localparam int DEDV_IDX_W = 14;

   localparam logic [13:0] DEDV_SRC_IDX [2] = '{14'h10DA, 14'h14DA};
   localparam logic [13:0] DEDV_RATIO_IDX [DEDV_NDIV] = '{
      14'h1100, 14'h1109, 14'h1112, 14'h111B, 14'h1124,
      14'h112D, 14'h1500, 14'h1509, 14'h1512, 14'h151B};
   localparam logic [13:0] DEDV_HALF_IDX [DEDV_NDIV] = '{
      14'h1108, 14'h1111, 14'h111A, 14'h1123, 14'h112C,
      14'h1135, 14'h1508, 14'h1511, 14'h151A, 14'h1523};
   localparam logic [13:0] DEDV_FB_IDX [DEDV_NFB] = '{
      14'h1202, 14'h1222, 14'h1242, 14'h1262, 14'h1282, 14'h12A2,
      14'h1602, 14'h1622, 14'h1642, 14'h1662, 14'h1682, 14'h16A2};
   localparam logic [13:0] DEDV_CTRL_IDX [DEDV_NPAIR] = '{
      14'h2102, 14'h2103, 14'h2104, 14'h2202, 14'h2203};
   localparam logic [13:0] DEDV_CMD_IDX  = 14'h2000;
   localparam logic [13:0] DEDV_STAT_IDX = 14'h2001;

   localparam int DEDV_SRC_MASK_BIT   = 0;
   localparam int DEDV_SRC_SEL_LSB    = 1;
   localparam int DEDV_HALF_BIT       = 5;
   localparam int DEDV_SHIFT_BIT      = 4;
   localparam int DEDV_RST_FIRST_BIT  = 1;
   localparam int DEDV_RST_SECOND_BIT = 0;
   localparam int DEDV_CMD_UPDATE_BIT = 0;
   localparam int DEDV_CMD_SYNC_BIT   = 1;
   localparam int DEDV_STAT_OUT_LSB   = 16;
   localparam int DEDV_FB_W           = 5;

   localparam logic [31:0] DEDV_RATIO_RST = 32'h0000_0000;
   localparam logic [3:0]  DEDV_SRC_RST   = 4'h0;
   localparam logic [4:0]  DEDV_FB_RST    = 5'h00;
   localparam logic [1:0]  DEDV_CTRL_RST  = 2'h0;
   localparam logic [1:0]  DEDV_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  DEDV_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [31:0] ratio;
      logic        half;
      logic        shift;
   } dedv_cfg_t;

   typedef enum logic [2:0] {
      DEDV_K_NONE, DEDV_K_SRC, DEDV_K_RATIO, DEDV_K_HALF,
      DEDV_K_FB, DEDV_K_CTRL, DEDV_K_CMD, DEDV_K_STAT
   } dedv_kind_t;

   typedef struct packed {
      dedv_kind_t kind;
      logic [3:0] num;
   } dedv_dec_t;
endpackage

// ==== dedv_top.sv ====
// Purpose: ten dual-edge output dividers with AXI4-Lite register access
// Assumes: divider source clocks arrive as pins and are oversampled by i_clk
// Notes:   outputs toggle at most once per sampled source edge
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module dedv_top (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [1:0]  i_analog_loop_clk,
   input  wire logic        i_sysclk_div3,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [15:0] i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [15:0] i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic [dedv_pkg::DEDV_NDIV-1:0] o_div_clk,
   output logic [dedv_pkg::DEDV_NFB-1:0]  o_fb_clk
);
   import dedv_pkg::*;

   // bus state
   logic              aw_hold_r;
   logic [13:0]       aw_idx_r;
   logic              w_hold_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;
   logic              wr_fire;
   logic              ar_fire;
   dedv_dec_t         wr_dec;
   dedv_dec_t         rd_dec;

   // register file
   logic [3:0]        src_r   [2];
   dedv_cfg_t         stage_r [DEDV_NDIV];
   dedv_cfg_t         act_r   [DEDV_NDIV];
   logic [4:0]        fb_r    [DEDV_NFB];
   logic [1:0]        ctrl_r  [DEDV_NPAIR];
   logic              upd_pulse;
   logic              sync_pulse;
   logic [1:0]        diff_any;
   logic [1:0]        chg_r;
   logic [1:0]        sync_ch;

   // source sampling and dividers
   logic [2:0]        meta_r;
   logic [2:0]        sync_r;
   logic [2:0]        prev_r;
   logic [2:0]        edge_v;
   logic [DEDV_NPAIR-1:0] pair_edge;
   logic [DEDV_NPAIR-1:0] pair_mask;
   logic [32:0]       cnt_r [DEDV_NDIV];
   logic [DEDV_NDIV-1:0] out_r;
   logic [DEDV_NDIV-1:0] en_r;
   logic [DEDV_NFB-1:0]  fb_clk_r;

   function automatic int chan_of_pair(input int p);
      return (p >= 3) ? 1 : 0;
   endfunction

   function automatic int local_pair(input int p);
      return (p >= 3) ? p - 3 : p;
   endfunction

   function automatic logic [32:0] edges_of(input dedv_cfg_t c);
      logic [31:0] r;
      r = (c.ratio == 32'h0000_0000) ? 32'h0000_0001 : c.ratio;
      return {r, 1'b0} + {32'h0000_0000, c.half};
   endfunction

   // high part of the period, optionally moved one input edge later
   function automatic logic [32:0] high_of(input dedv_cfg_t c, input logic may_shift);
      logic [31:0] r;
      logic [32:0] h;
      r = (c.ratio == 32'h0000_0000) ? 32'h0000_0001 : c.ratio;
      h = {1'b0, r} + {32'h0000_0000, c.half};
      if (may_shift && c.shift && r > 32'h0000_0001) begin
         h = h + 33'h0_0000_0001;
      end
      return h;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      logic [31:0] m;
      m = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            m[8*b +: 8] = n[8*b +: 8];
         end
      end
      return m;
   endfunction

   function automatic dedv_dec_t decode(input logic [13:0] idx);
      dedv_dec_t d;
      d.kind = DEDV_K_NONE;
      d.num  = 4'h0;
      for (int k = 0; k < 2; k++) begin
         if (idx == DEDV_SRC_IDX[k]) begin
            d.kind = DEDV_K_SRC;
            d.num  = 4'(k);
         end
      end
      for (int k = 0; k < DEDV_NDIV; k++) begin
         if (idx == DEDV_RATIO_IDX[k]) begin
            d.kind = DEDV_K_RATIO;
            d.num  = 4'(k);
         end
         if (idx == DEDV_HALF_IDX[k]) begin
            d.kind = DEDV_K_HALF;
            d.num  = 4'(k);
         end
      end
      for (int k = 0; k < DEDV_NFB; k++) begin
         if (idx == DEDV_FB_IDX[k]) begin
            d.kind = DEDV_K_FB;
            d.num  = 4'(k);
         end
      end
      for (int k = 0; k < DEDV_NPAIR; k++) begin
         if (idx == DEDV_CTRL_IDX[k]) begin
            d.kind = DEDV_K_CTRL;
            d.num  = 4'(k);
         end
      end
      if (idx == DEDV_CMD_IDX) begin
         d.kind = DEDV_K_CMD;
      end
      if (idx == DEDV_STAT_IDX) begin
         d.kind = DEDV_K_STAT;
      end
      return d;
   endfunction

   function automatic logic soft_rst(input logic [1:0] c, input int i);
      return (i % 2 == 0) ? c[DEDV_RST_FIRST_BIT] : c[DEDV_RST_SECOND_BIT];
   endfunction

   // AXI4-Lite handshakes
   assign o_awready = !aw_hold_r && !bvalid_r;
   assign o_wready  = !w_hold_r && !bvalid_r;
   assign o_arready = !rvalid_r;
   assign o_bvalid  = bvalid_r;
   assign o_bresp   = bresp_r;
   assign o_rvalid  = rvalid_r;
   assign o_rdata   = rdata_r;
   assign o_rresp   = rresp_r;
   assign wr_fire   = aw_hold_r && w_hold_r && !bvalid_r;
   assign ar_fire   = i_arvalid && !rvalid_r;
   assign wr_dec    = decode(aw_idx_r);
   assign rd_dec    = decode(i_araddr[15:2]);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_hold_r <= 1'b0;
         aw_idx_r  <= 14'h0000;
         w_hold_r  <= 1'b0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_hold_r <= 1'b1;
            aw_idx_r  <= i_awaddr[15:2];
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= i_wdata;
            wstrb_r  <= i_wstrb;
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= DEDV_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (wr_dec.kind == DEDV_K_NONE || wr_dec.kind == DEDV_K_STAT) ?
                     DEDV_RESP_SLVERR : DEDV_RESP_OKAY;
      end else if (i_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= DEDV_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rresp_r  <= DEDV_RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
         case (rd_dec.kind)
            DEDV_K_SRC: begin
               rdata_r <= {28'h000_0000, src_r[rd_dec.num[0]]};
            end
            DEDV_K_RATIO: begin
               rdata_r <= stage_r[rd_dec.num].ratio;
            end
            DEDV_K_HALF: begin
               rdata_r[DEDV_HALF_BIT]  <= stage_r[rd_dec.num].half;
               rdata_r[DEDV_SHIFT_BIT] <= stage_r[rd_dec.num].shift;
            end
            DEDV_K_FB: begin
               rdata_r <= {27'h000_0000, fb_r[rd_dec.num]};
            end
            DEDV_K_CTRL: begin
               rdata_r <= {30'h0000_0000, ctrl_r[rd_dec.num[2:0]]};
            end
            DEDV_K_CMD: begin
               rdata_r <= 32'h0000_0000;
            end
            DEDV_K_STAT: begin
               rdata_r <= {6'h00, out_r, 6'h00, en_r};
            end
            default: begin
               rresp_r <= DEDV_RESP_SLVERR;
            end
         endcase
      end else if (i_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ratio and half-step writes land in the staged copy; source, feedback and control act at once
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < 2; k++) begin
            src_r[k] <= DEDV_SRC_RST;
         end
         for (int k = 0; k < DEDV_NDIV; k++) begin
            stage_r[k] <= '{ratio: DEDV_RATIO_RST, half: 1'b0, shift: 1'b0};
         end
         for (int k = 0; k < DEDV_NFB; k++) begin
            fb_r[k] <= DEDV_FB_RST;
         end
         for (int k = 0; k < DEDV_NPAIR; k++) begin
            ctrl_r[k] <= DEDV_CTRL_RST;
         end
      end else if (wr_fire) begin
         case (wr_dec.kind)
            DEDV_K_SRC: begin
               if (wstrb_r[0]) begin
                  src_r[wr_dec.num[0]] <= wdata_r[3:0];
               end
            end
            DEDV_K_RATIO: begin
               stage_r[wr_dec.num].ratio <= merge(stage_r[wr_dec.num].ratio, wdata_r,
                                                  wstrb_r);
            end
            DEDV_K_HALF: begin
               if (wstrb_r[0]) begin
                  stage_r[wr_dec.num].half  <= wdata_r[DEDV_HALF_BIT];
                  stage_r[wr_dec.num].shift <= wdata_r[DEDV_SHIFT_BIT];
               end
            end
            DEDV_K_FB: begin
               if (wstrb_r[0]) begin
                  fb_r[wr_dec.num] <= wdata_r[DEDV_FB_W-1:0];
               end
            end
            DEDV_K_CTRL: begin
               if (wstrb_r[0]) begin
                  ctrl_r[wr_dec.num[2:0]] <= wdata_r[1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign upd_pulse  = wr_fire && wr_dec.kind == DEDV_K_CMD && wstrb_r[0] &&
                       wdata_r[DEDV_CMD_UPDATE_BIT];
   assign sync_pulse = wr_fire && wr_dec.kind == DEDV_K_CMD && wstrb_r[0] &&
                       wdata_r[DEDV_CMD_SYNC_BIT];

   always_comb begin
      diff_any = 2'b00;
      for (int i = 0; i < DEDV_NDIV; i++) begin
         if (stage_r[i].ratio != act_r[i].ratio || stage_r[i].half != act_r[i].half) begin
            diff_any[chan_of_pair(i / 2)] = 1'b1;
         end
      end
   end

   // all staged settings become active in one cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < DEDV_NDIV; k++) begin
            act_r[k] <= '{ratio: DEDV_RATIO_RST, half: 1'b0, shift: 1'b0};
         end
      end else if (upd_pulse) begin
         for (int k = 0; k < DEDV_NDIV; k++) begin
            act_r[k] <= stage_r[k];
         end
      end
   end

   // a ratio change resyncs its channel one cycle after the update
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         chg_r <= 2'b00;
      end else begin
         chg_r <= upd_pulse ? diff_any : 2'b00;
      end
   end

   assign sync_ch = {2{sync_pulse}} | chg_r;

   // source pins: two flops, then an edge of either polarity
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= 3'h0;
         sync_r <= 3'h0;
         prev_r <= 3'h0;
      end else begin
         meta_r <= {i_sysclk_div3, i_analog_loop_clk};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign edge_v = sync_r ^ prev_r;

   always_comb begin
      for (int p = 0; p < DEDV_NPAIR; p++) begin
         if (src_r[chan_of_pair(p)][DEDV_SRC_SEL_LSB + local_pair(p)]) begin
            pair_edge[p] = edge_v[2];
         end else begin
            pair_edge[p] = edge_v[chan_of_pair(p)];
         end
         pair_mask[p] = src_r[chan_of_pair(p)][DEDV_SRC_SEL_LSB + local_pair(p)] &&
                        src_r[chan_of_pair(p)][DEDV_SRC_MASK_BIT];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < DEDV_NDIV; i++) begin
            cnt_r[i] <= 33'h0_0000_0000;
         end
         out_r <= '0;
         en_r  <= '0;
      end else begin
         for (int i = 0; i < DEDV_NDIV; i++) begin
            if (sync_ch[chan_of_pair(i / 2)] && !pair_mask[i / 2]) begin
               cnt_r[i] <= edges_of(act_r[i]) - 33'h0_0000_0001;
               out_r[i] <= 1'b0;
               en_r[i]  <= 1'b1;
            end else if (soft_rst(ctrl_r[i / 2], i)) begin
               cnt_r[i] <= edges_of(act_r[i]) - 33'h0_0000_0001;
               out_r[i] <= 1'b0;
            end else if (en_r[i] && pair_edge[i / 2]) begin
               if (cnt_r[i] >= edges_of(act_r[i]) - 33'h0_0000_0001) begin
                  cnt_r[i] <= 33'h0_0000_0000;
                  out_r[i] <= 1'b1;
               end else begin
                  cnt_r[i] <= cnt_r[i] + 33'h0_0000_0001;
                  out_r[i] <= (cnt_r[i] + 33'h0_0000_0001) <
                              high_of(act_r[i], i % 2 == 0);
               end
            end
         end
      end
   end

   assign o_div_clk = out_r;

   // feedback taps, out-of-range selections give a quiet line
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         fb_clk_r <= '0;
      end else begin
         for (int j = 0; j < DEDV_NFB; j++) begin
            fb_clk_r[j] <= (fb_r[j] < 5'(DEDV_NDIV)) ? out_r[fb_r[j][3:0]] : 1'b0;
         end
      end
   end

   assign o_fb_clk = fb_clk_r;

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence loop0_rise_s;
      sync_r[0] && !prev_r[0];
   endsequence

   sequence loop0_fall_s;
      !sync_r[0] && prev_r[0];
   endsequence

   sequence div0_free_s;
      en_r[0] && !src_r[0][DEDV_SRC_SEL_LSB] && !sync_ch[0] &&
      !ctrl_r[0][DEDV_RST_FIRST_BIT];
   endsequence

   count_rise_a: assert property ((loop0_rise_s and div0_free_s) |=>
      cnt_r[0] != $past(cnt_r[0])) else $error("divider missed a rising edge");

   count_fall_a: assert property ((loop0_fall_s and div0_free_s) |=>
      cnt_r[0] != $past(cnt_r[0])) else $error("divider missed a falling edge");

   off_quiet_a: assert property ((out_r & ~en_r) == '0)
      else $error("disabled divider produced a clock");

   pair_shared_a: assert property ((edge_v[2] && src_r[0][DEDV_SRC_SEL_LSB] &&
      en_r[1:0] == 2'b11 && !sync_ch[0] && ctrl_r[0] == 2'b00) |=>
      (cnt_r[0] != $past(cnt_r[0]) && cnt_r[1] != $past(cnt_r[1])))
      else $error("pair did not advance together on system clock");

   source_ignore_a: assert property ((src_r[0][DEDV_SRC_SEL_LSB] && edge_v[0] &&
      !edge_v[2] && !sync_ch[0] && ctrl_r[0] == 2'b00) |=> $stable(cnt_r[0]))
      else $error("deselected loop clock moved the divider");

   mask_keep_a: assert property ((sync_ch[0] && pair_mask[0] && en_r[0] &&
      !ctrl_r[0][DEDV_RST_FIRST_BIT] && !pair_edge[0]) |=>
      (en_r[0] && $stable(cnt_r[0]) && $stable(out_r[0])))
      else $error("masked divider was resynchronized");

   staged_hold_a: assert property (!upd_pulse |=> $stable(act_r[2]))
      else $error("active ratio changed without update strobe");

   half_hold_a: assert property (!upd_pulse |=> $stable(act_r[3].half))
      else $error("half step changed without update strobe");

   copy_all_a: assert property (upd_pulse |=>
      (act_r[0] == $past(stage_r[0]) && act_r[9] == $past(stage_r[9])))
      else $error("update strobe did not copy staged settings");

   soft_reset_a: assert property (ctrl_r[0][DEDV_RST_FIRST_BIT] && !sync_ch[0] |=>
      !out_r[0] ##0 cnt_r[0] == $past(edges_of(act_r[0])) - 33'h0_0000_0001)
      else $error("soft reset did not hold divider");

   ratio_sync_a: assert property ((upd_pulse && diff_any[1] && !pair_mask[3]) |->
      ##2 en_r[6]) else $error("ratio change did not resync channel");

   rise_at_wrap_a: assert property ($rose(out_r[1]) |-> cnt_r[1] == 33'h0_0000_0000)
      else $error("output rose away from period start");

   fb_route_a: assert property ($past(fb_r[0]) == 5'h01 |->
      o_fb_clk[0] == $past(out_r[1])) else $error("feedback tap selects wrong divider");

   write_resp_a: assert property (wr_fire |=> bvalid_r [*1] ##0 !aw_hold_r)
      else $error("write response missing");
endmodule

// ==== dedv_top_tb.sv ====
// Purpose: self-checking bench for the dual-edge output dividers
// Assumes: source pins toggle every four i_clk cycles, so one edge is four cycles
// Notes:   periods are counted in i_clk cycles between output rises
`timescale 1ns/10ps
module dedv_top_tb;
   import dedv_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [1:0]  alc = 2'h0;
   logic        sck = 1'b0;
   logic [2:0]  run = 3'h0;
   logic [1:0]  tick = 2'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000, rd, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic [1:0]  bresp, rresp, rr, wb;
   logic        awready, wready, bvalid, arready, rvalid, pv;
   logic [9:0]  div_clk;
   logic [11:0] fb_clk;
   int          bad_count = 0, checks_done = 0, seed = 78;
   int          r0, r1 = 0, h0 = 0, h1, n, j;

   always #25 i_clk = ~i_clk;

   // free-running source pins, gated by run
   always @(posedge i_clk) begin
      tick <= tick + 2'h1;
      // loop pins toggle off the system clock phase, so their edges never coincide
      if (tick == 2'h1) begin
         alc <= alc ^ run[1:0];
      end
      if (tick == 2'h3) begin
         sck <= sck ^ run[2];
      end
   end

   dedv_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_analog_loop_clk(alc), .i_sysclk_div3(sck),
      .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
      .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
      .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
      .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
      .o_rresp(rresp), .o_div_clk(div_clk), .o_fb_clk(fb_clk));

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic hang();
      bad_count++;
      $display("[FAIL] %0t ns: wait ran out", $time);
      complete_run();
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [13:0] idx, input logic [31:0] d);
      logic ta, tw, b;
      int k;
      b = 1'b0;
      @(posedge i_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      for (k = 0; k < 50 && !b; k++) begin
         @(negedge i_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         b = bvalid;
         wb = bresp;
         @(posedge i_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!b) hang();
   endtask

   task automatic rdreg(input logic [13:0] idx);
      logic ta, got;
      int k;
      got = 1'b0;
      @(posedge i_clk);
      arvalid <= 1'b1;
      araddr <= {idx, 2'b00};
      rready <= 1'b1;
      for (k = 0; k < 50 && !got; k++) begin
         @(negedge i_clk);
         ta = arvalid && arready;
         got = rvalid;
         rd = rdata;
         rr = rresp;
         @(posedge i_clk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!got) hang();
   endtask

   task automatic wl(input int d, input logic l, inout int c);
      int k;
      for (k = 0; k < 400 && div_clk[d] !== l; k++) begin
         @(negedge i_clk);
         c++;
      end
      if (div_clk[d] !== l) hang();
   endtask

   // skips two rises, then times one full period
   task automatic per(input int d, input int e);
      int c;
      c = 0;
      repeat (2) begin
         wl(d, 1'b0, c);
         wl(d, 1'b1, c);
      end
      c = 0;
      wl(d, 1'b0, c);
      wl(d, 1'b1, c);
      chk(c, e * 4);
   endtask

   task automatic lowfor(input int d, input int cyc);
      int k, hi;
      hi = 0;
      for (k = 0; k < cyc; k++) begin
         @(negedge i_clk);
         hi += (div_clk[d] !== 1'b0);
      end
      chk(hi, 0);
   endtask

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      rdreg(DEDV_RATIO_IDX[3]);
      chk(rd, DEDV_RATIO_RST);
      rdreg(14'h0000);
      chk(rr, DEDV_RESP_SLVERR);
      r0 = $random(seed);
      for (j = 0; j < 2; j++) begin
         wr(DEDV_RATIO_IDX[7], j ? r0 : 32'hFFFF_FFFF);
         rdreg(DEDV_RATIO_IDX[7]);
         chk(rd, j ? r0 : 32'hFFFF_FFFF);
      end
      chk(wb, DEDV_RESP_OKAY);
      wr(14'h0000, 32'h0000_0000);
      chk(wb, DEDV_RESP_SLVERR);
      $display("register access test done");
      run <= 3'b001;
      lowfor(0, 100);
      r1 = 2 + ($unsigned($random(seed)) % 4);
      wr(DEDV_RATIO_IDX[0], r1);
      wr(DEDV_RATIO_IDX[1], r1);
      wr(DEDV_CMD_IDX, 32'h0000_0001);
      wr(DEDV_CMD_IDX, 32'h0000_0002);
      per(0, 2 * r1);
      per(1, 2 * r1);
      $display("startup test done");
      for (j = 0; j < 3; j++) begin
         r0 = 2 + ($unsigned($random(seed)) % 4);
         h1 = $random(seed) & 1;
         wr(DEDV_RATIO_IDX[0], r0);
         wr(DEDV_RATIO_IDX[1], r0);
         wr(DEDV_HALF_IDX[0], h1 << DEDV_HALF_BIT);
         wr(DEDV_HALF_IDX[1], h1 << DEDV_HALF_BIT);
         per(0, 2 * r1 + h0);
         wr(DEDV_CMD_IDX, 32'h0000_0001);
         per(0, 2 * r0 + h1);
         per(1, 2 * r0 + h1);
         r1 = r0;
         h0 = h1;
      end
      $display("ratio update test done");
      wr(DEDV_CTRL_IDX[0], 32'h0000_0002);
      lowfor(0, 100);
      per(1, 2 * r1 + h0);
      wr(DEDV_CTRL_IDX[0], 32'h0000_0000);
      wr(DEDV_FB_IDX[0], 32'h0000_0001);
      n = 0;
      @(negedge i_clk);
      for (j = 0; j < 60; j++) begin
         pv = div_clk[1];
         @(negedge i_clk);
         n += (fb_clk[0] !== pv);
      end
      chk(n, 0);
      $display("reset and feedback test done");
      // edge shift on the first divider of pair 0, pair partner unshifted
      wr(DEDV_RATIO_IDX[0], 32'h0000_0008);
      wr(DEDV_RATIO_IDX[1], 32'h0000_0008);
      wr(DEDV_HALF_IDX[0], 32'h0000_0001 << DEDV_SHIFT_BIT);
      wr(DEDV_HALF_IDX[1], 32'h0000_0000);
      wr(DEDV_CMD_IDX, 32'h0000_0001);
      r1 = 8;
      h0 = 0;
      per(0, 2 * r1);
      n = 0;
      wl(1, 1'b1, n);
      wl(1, 1'b0, n);
      n = 0;
      wl(0, 1'b0, n);
      chk(n, 4);
      $display("edge shift test done");
      run <= 3'b101;
      wr(DEDV_SRC_IDX[0], 32'h0000_0002);
      wr(DEDV_CTRL_IDX[0], 32'h0000_0002);
      wr(DEDV_CTRL_IDX[0], 32'h0000_0000);
      wr(DEDV_CMD_IDX, 32'h0000_0002);
      per(0, 2 * r1 + h0);
      wr(DEDV_SRC_IDX[0], 32'h0000_0003);
      n = 0;
      wl(0, 1'b0, n);
      wl(0, 1'b1, n);
      run <= 3'b000;
      repeat (10) @(negedge i_clk);
      wr(DEDV_CMD_IDX, 32'h0000_0002);
      @(negedge i_clk);
      chk(div_clk[0], 1);
      wr(DEDV_SRC_IDX[0], 32'h0000_0002);
      wr(DEDV_CMD_IDX, 32'h0000_0002);
      @(negedge i_clk);
      chk(div_clk[0], 0);
      $display("source select test done");
      complete_run();
   end
endmodule
